// ### hw/dacwd_regs.vh
// Summary of operation
// [RULE1] plain word is exactly 24 bits
// [RULE2] check mode: 32 bits, last eight check
// [RULE3] msb first: rw, unit, class, channel, data
// [RULE4] act only when unit bits match straps
// [RULE5] class 000 data, 110 clear, 111 control
// [RULE6] control class decodes a further data field
// [RULE7] channel bits pick A to D
// [RULE8] class 010 writes channel gain trim
// [RULE9] class 011 writes gain on all channels
// [RULE10] gain straight binary, resets to all ones
// [RULE11] host keeps gain trim near half range
// [RULE12] class 100 writes channel offset trim
// [RULE13] class 101 writes offset on all channels
// [RULE14] offset midpoint means zero, resets midpoint
// [RULE15] per channel clear code, resets to zero
// [RULE16] clear loads code only on enabled channels
// [RULE17] data write starts 200 us calibration
// [RULE18] control target field sits at D15 to D13
// [RULE19] commit only after complete closed frame
`ifndef DACWD_REGS_VH
`define DACWD_REGS_VH

// ==========================================================
// word layout
`define DACWD_LEN_PLAIN     6'h18
`define DACWD_LEN_CHECKED   6'h20
`define DACWD_POS_RW        23
`define DACWD_POS_UNIT_HI   22
`define DACWD_POS_UNIT_LO   21
`define DACWD_POS_CLASS_HI  20
`define DACWD_POS_CLASS_LO  18
`define DACWD_POS_CHAN_HI   17
`define DACWD_POS_CHAN_LO   16
`define DACWD_POS_CTRL_HI   15
`define DACWD_POS_CTRL_LO   13

// ==========================================================
// register classes
`define DACWD_CLS_DATA      3'h0
`define DACWD_CLS_GAIN      3'h2
`define DACWD_CLS_GAIN_ALL  3'h3
`define DACWD_CLS_OFS       3'h4
`define DACWD_CLS_OFS_ALL   3'h5
`define DACWD_CLS_CLEAR     3'h6
`define DACWD_CLS_CTRL      3'h7
`define DACWD_CTRL_DAC      3'h2

// ==========================================================
// dac control bits kept by this block
`define DACWD_POS_OUTPUT_DRIVE_ENABLE     6
`define DACWD_POS_CLR_EN    5

// ==========================================================
// trim memory map: kind in addr[3:2], channel in addr[1:0]
`define DACWD_KIND_GAIN     2'h0
`define DACWD_KIND_OFS      2'h1
`define DACWD_KIND_CLEAR    2'h2

// ==========================================================
// reset values
`define DACWD_RST_GAIN      16'hFFFF
`define DACWD_RST_OFS       16'h8000
`define DACWD_RST_CLEAR     16'h0000
`define DACWD_RST_CODE      16'h0000

// ==========================================================
// timing
`define DACWD_CLK_PERIOD_NS 100
`define DACWD_CAL_TIME_NS   200000

`endif

// ### hw/dacwd_sync.v
`timescale 1ns/1ps
module dacwd_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // levels
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] stage1;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= {W{1'b0}};
            q_o    <= {W{1'b0}};
        end else begin
            stage1 <= d_i;
            q_o    <= stage1;
        end
    end
endmodule

// ### hw/dacwd_mem.v
`timescale 1ns/1ps
`include "dacwd_regs.vh"
module dacwd_mem #(
    parameter DW = 16,
    parameter AW = 4
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_i,
    // write port
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [DW-1:0] wdata_i,
    // read port
    input  wire          re_i,
    input  wire [AW-1:0] raddr_i,
    output reg  [DW-1:0] rdata_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // kind sits in the upper address bits
    function [DW-1:0] rst_val;
        input [1:0] kind;
        begin
            if (kind == `DACWD_KIND_GAIN)
                rst_val = `DACWD_RST_GAIN;    // [RULE10]
            else if (kind == `DACWD_KIND_OFS)
                rst_val = `DACWD_RST_OFS;     // [RULE14]
            else
                rst_val = `DACWD_RST_CLEAR;   // [RULE15]
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < (1<<AW); g = g + 1) begin : word
            localparam [AW-1:0] ADDR = g;
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i)
                    mem[g] <= rst_val(ADDR[AW-1:AW-2]);
                else if (we_i && waddr_i == ADDR)
                    mem[g] <= wdata_i;
            end
        end
    endgenerate

    // read before write on a same-address collision
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            rdata_o <= {DW{1'b0}};
        else if (re_i)
            rdata_o <= mem[raddr_i];
    end
endmodule

// ### hw/dacwd_top.v
`timescale 1ns/1ps
`include "dacwd_regs.vh"
module dacwd_top #(
    parameter DW = 16,
    parameter NCH = 4
) (
    // clock and reset
    input  wire            core_clk_i,
    input  wire            rst_i,
    // serial link pins
    input  wire            sclk_i,
    input  wire            sdin_i,
    input  wire            sync_n_i,
    // strap and clear pins
    input  wire            strap_pin_hi_i,
    input  wire            strap_pin_lo_i,
    input  wire            clear_i,
    // configuration
    input  wire            packet_check_en_i,
    // trim read port
    input  wire            trim_rd_i,
    input  wire [3:0]      trim_addr_i,
    output reg  [DW-1:0]   trim_data_o,
    output reg             trim_valid_o,
    // channel outputs
    output reg  [NCH*DW-1:0] dac_code_o,
    output reg  [NCH-1:0]  output_drive_enable_o,
    output reg  [NCH-1:0]  clear_enable_o,
    output reg  [NCH-1:0]  cal_busy_o,
    // frame status
    output reg  [7:0]      packet_check_code_o,
    output reg             frame_ok_o,
    output reg             frame_err_o
);
    // ==========================================================
    // constants
    localparam integer CAL_CYC_I =
        (`DACWD_CAL_TIME_NS + `DACWD_CLK_PERIOD_NS - 1) /
        `DACWD_CLK_PERIOD_NS;
    localparam [11:0] CAL_CYC = CAL_CYC_I[11:0];

    // ==========================================================
    // pin synchronisers
    wire [5:0] pin_raw;
    wire [5:0] pin_s;
    wire       s_sclk;
    wire       s_sdin;
    wire       s_sync_n;
    wire       s_strap_lo;
    wire       s_strap_hi;
    wire       s_clear;

    // frame pin travels inverted so a reset chain reads it idle high
    assign pin_raw = {clear_i, strap_pin_hi_i, strap_pin_lo_i,
                      ~sync_n_i, sdin_i, sclk_i};

    dacwd_sync #(
        .W (6)
    ) u_sync (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .d_i   (pin_raw),
        .q_o   (pin_s)
    );

    assign s_sclk     = pin_s[0];
    assign s_sdin     = pin_s[1];
    assign s_sync_n   = ~pin_s[2];
    assign s_strap_lo = pin_s[3];
    assign s_strap_hi = pin_s[4];
    assign s_clear    = pin_s[5];

    // ==========================================================
    // edge detection on synchronised levels
    reg sclk_d;
    reg sync_n_d;
    reg clear_d;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d   <= 1'b0;
            sync_n_d <= 1'b1;
            clear_d  <= 1'b0;
        end else begin
            sclk_d   <= s_sclk;
            sync_n_d <= s_sync_n;
            clear_d  <= s_clear;
        end
    end

    wire sclk_fall   = sclk_d & ~s_sclk;
    wire frame_start = sync_n_d & ~s_sync_n;
    wire frame_end   = ~sync_n_d & s_sync_n;
    // a held clear level does not clear again; only a new rise
    wire clear_rise  = s_clear & ~clear_d;

    // ==========================================================
    // shift register, msb first on falling serial clock
    reg  [31:0] shreg;
    reg  [5:0]  bitcnt;
    wire [5:0]  base_cnt = frame_start ? 6'h00 : bitcnt;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shreg  <= 32'h0000_0000;
            bitcnt <= 6'h00;
        end else if (~s_sync_n && sclk_fall) begin
            shreg <= {shreg[30:0], s_sdin};              // [RULE3]
            // saturate so an overlong frame never wraps to a match
            if (base_cnt != 6'h3F)
                bitcnt <= base_cnt + 6'h01;
            else
                bitcnt <= base_cnt;
        end else if (frame_start) begin
            bitcnt <= 6'h00;
        end
    end

    // ==========================================================
    // frame decode
    wire [5:0]  exp_len = packet_check_en_i ? `DACWD_LEN_CHECKED
                                            : `DACWD_LEN_PLAIN;
    wire [23:0] payload = packet_check_en_i ? shreg[31:8]
                                            : shreg[23:0];
    wire        len_ok  = (bitcnt == exp_len);         // [RULE1] [RULE2]
    wire        rw_bit  = payload[`DACWD_POS_RW];
    wire [1:0]  unit    = payload[`DACWD_POS_UNIT_HI:`DACWD_POS_UNIT_LO];
    wire [2:0]  cls     = payload[`DACWD_POS_CLASS_HI:`DACWD_POS_CLASS_LO];
    wire [1:0]  chan    = payload[`DACWD_POS_CHAN_HI:`DACWD_POS_CHAN_LO];
    wire [2:0]  ctrl    = payload[`DACWD_POS_CTRL_HI:`DACWD_POS_CTRL_LO];
    wire [15:0] data    = payload[15:0];
    // straps are read live; move them only between frames
    wire        unit_ok = (unit == {s_strap_hi, s_strap_lo}); // [RULE4]
    // reads are not served here, so only writes act
    wire        act     = frame_end & len_ok & ~rw_bit & unit_ok; // [RULE19]

    function [3:0] chan_onehot;
        input [1:0] c;
        begin
            chan_onehot = 4'h1 << c;                     // [RULE7]
        end
    endfunction

    wire [3:0] chan_sel = chan_onehot(chan);
    wire       do_data  = act && (cls == `DACWD_CLS_DATA);  // [RULE5]
    wire       do_dctl  = act && (cls == `DACWD_CLS_CTRL) &&
                          (ctrl == `DACWD_CTRL_DAC);   // [RULE6] [RULE18]
    wire [3:0] cal_start = do_data ? chan_sel : 4'h0;  // [RULE17]

    // ==========================================================
    // trim write sequencer; broadcast walks all channels
    reg        wr_active;
    reg        wr_all;
    reg [1:0]  wr_kind;
    reg [1:0]  wr_ch;
    reg [15:0] wr_data;
    reg [1:0]  next_kind;
    reg        next_all;
    reg        next_mem;

    always @* begin
        next_kind = `DACWD_KIND_GAIN;
        next_all  = 1'b0;
        next_mem  = 1'b1;
        case (cls)
            `DACWD_CLS_GAIN: begin                        // [RULE8]
                next_kind = `DACWD_KIND_GAIN;
            end
            `DACWD_CLS_GAIN_ALL: begin                    // [RULE9]
                next_kind = `DACWD_KIND_GAIN;
                next_all  = 1'b1;
            end
            `DACWD_CLS_OFS: begin                         // [RULE12]
                next_kind = `DACWD_KIND_OFS;
            end
            `DACWD_CLS_OFS_ALL: begin                     // [RULE13]
                next_kind = `DACWD_KIND_OFS;
                next_all  = 1'b1;
            end
            `DACWD_CLS_CLEAR: begin                       // [RULE5]
                next_kind = `DACWD_KIND_CLEAR;
            end
            default: begin
                next_mem = 1'b0;
            end
        endcase
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_active <= 1'b0;
            wr_all    <= 1'b0;
            wr_kind   <= 2'h0;
            wr_ch     <= 2'h0;
            wr_data   <= 16'h0000;
        end else if (act && next_mem) begin
            wr_active <= 1'b1;
            wr_all    <= next_all;
            wr_kind   <= next_kind;
            wr_ch     <= next_all ? 2'h0 : chan;
            wr_data   <= data;
        end else if (wr_active) begin
            if (!wr_all || wr_ch == 2'h3)
                wr_active <= 1'b0;
            else
                wr_ch <= wr_ch + 2'h1;
        end
    end

    // ==========================================================
    // read arbitration: clear sweep before trim reads
    reg        clr_active;
    reg [1:0]  clr_ch;
    reg        rd_clr;
    reg        rd_trim;
    reg [1:0]  rd_ch;
    wire       trim_go = trim_rd_i & ~clr_active;
    wire       mem_re  = clr_active | trim_go;
    reg  [3:0] mem_raddr;
    wire [15:0] mem_rdata;

    // a trim read that meets the sweep is dropped, not queued
    always @* begin
        if (clr_active)
            mem_raddr = {`DACWD_KIND_CLEAR, clr_ch};
        else
            mem_raddr = trim_addr_i;
    end

    dacwd_mem #(
        .DW (DW),
        .AW (4)
    ) u_mem (
        .clk_i   (core_clk_i),
        .rst_i   (rst_i),
        .we_i    (wr_active),
        .waddr_i ({wr_kind, wr_ch}),
        .wdata_i (wr_data),
        .re_i    (mem_re),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_active <= 1'b0;
            clr_ch     <= 2'h0;
            rd_clr     <= 1'b0;
            rd_trim    <= 1'b0;
            rd_ch      <= 2'h0;
        end else begin
            rd_clr  <= clr_active;
            rd_trim <= trim_go;
            rd_ch   <= clr_ch;
            if (clear_rise) begin
                clr_active <= 1'b1;
                clr_ch     <= 2'h0;
            end else if (clr_active) begin
                if (clr_ch == 2'h3)
                    clr_active <= 1'b0;
                clr_ch <= clr_ch + 2'h1;
            end
        end
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trim_data_o  <= 16'h0000;
            trim_valid_o <= 1'b0;
        end else begin
            trim_valid_o <= rd_trim;
            if (rd_trim)
                trim_data_o <= mem_rdata;
        end
    end

    // ==========================================================
    // output codes and dac control bits
    integer i;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dac_code_o            <= {NCH{`DACWD_RST_CODE}};
            output_drive_enable_o <= {NCH{1'b0}};
            clear_enable_o        <= {NCH{1'b0}};
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                if (do_data && chan_sel[i])
                    dac_code_o[i*DW +: DW] <= data;
                if (do_dctl && chan_sel[i]) begin
                    output_drive_enable_o[i] <= data[`DACWD_POS_OUTPUT_DRIVE_ENABLE];
                    clear_enable_o[i]        <= data[`DACWD_POS_CLR_EN];
                end
                // clear load last so it wins over a data write
                if (rd_clr && rd_ch == i[1:0] && clear_enable_o[i])
                    dac_code_o[i*DW +: DW] <= mem_rdata;   // [RULE16]
            end
        end
    end

    // ==========================================================
    // frame status
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_ok_o          <= 1'b0;
            frame_err_o         <= 1'b0;
            packet_check_code_o <= 8'h00;
        end else begin
            // a refused word still reports its framing
            frame_ok_o  <= frame_end & len_ok;
            frame_err_o <= frame_end & ~len_ok;            // [RULE19]
            // check code is passed on, not verified here
            if (frame_end && len_ok && packet_check_en_i)
                packet_check_code_o <= shreg[7:0];         // [RULE2]
        end
    end

    // ==========================================================
    // calibration timers, one per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : cal
            reg  [11:0] cnt;
            reg  [11:0] next_cnt;
            // a rewrite while busy restarts the full wait
            always @* begin
                if (cal_start[g])
                    next_cnt = CAL_CYC;
                else if (cnt != 12'h000)
                    next_cnt = cnt - 12'h001;
                else
                    next_cnt = 12'h000;
            end
            always @(posedge core_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    cnt           <= 12'h000;
                    cal_busy_o[g] <= 1'b0;
                end else begin
                    cnt           <= next_cnt;          // [RULE17]
                    cal_busy_o[g] <= (next_cnt != 12'h000);
                end
            end
        end
    endgenerate
endmodule

// ### dv/diwd_host_model.sv
`timescale 1ns/1ps
module diwd_host_model (
    // serial link toward the device
    output logic sclk_o,
    output logic sdin_o,
    output logic sync_n_o
);
    initial begin
        sclk_o = 1'b1;
        sdin_o = 1'b0;
        sync_n_o = 1'b1;
    end

    // ==========================================================
    // one frame, n is 24 plain or 32 checked
    task automatic send(input logic [31:0] w, input int n);
        int i;
        sync_n_o = 1'b0;
        #400;
        for (i = 0; i < n; i++) begin
            sdin_o = w[31-i];
            #400;
            sclk_o = 1'b0;
            #400;
            sclk_o = 1'b1;
        end
        #400;
        sync_n_o = 1'b1;
        // released line has no pull: show the inverse
        sdin_o = ~sdin_o;
        #2000;
    endtask
endmodule

// ### dv/diwd_asserts.sv
`timescale 1ns/1ps
module diwd_asserts #(
    parameter DW  = 16,
    parameter NCH = 4
) (
    // clock and reset
    input wire               core_clk_i,
    input wire               rst_i,
    // pins and requests
    input wire               sclk_i,
    input wire               sdin_i,
    input wire               sync_n_i,
    input wire               strap_pin_hi_i,
    input wire               strap_pin_lo_i,
    input wire               clear_i,
    input wire               packet_check_en_i,
    input wire               trim_rd_i,
    input wire [3:0]         trim_addr_i,
    // design outputs
    input wire [DW-1:0]      trim_data_o,
    input wire               trim_valid_o,
    input wire [NCH*DW-1:0]  dac_code_o,
    input wire [NCH-1:0]     output_drive_enable_o,
    input wire [NCH-1:0]     clear_enable_o,
    input wire [NCH-1:0]     cal_busy_o,
    input wire [7:0]         packet_check_code_o,
    input wire               frame_ok_o,
    input wire               frame_err_o
);
    reg        clr_q;
    reg [3:0]  clr_age;
    reg [11:0] busy_cnt;

    // ==========================================================
    // clear age saturates so late code changes stay flagged
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_q <= 1'b0;
            clr_age <= 4'hF;
            busy_cnt <= 12'h000;
        end else begin
            clr_q <= clear_i;
            if (clear_i && !clr_q)
                clr_age <= 4'h0;
            else if (clr_age != 4'hF)
                clr_age <= clr_age + 4'h1;
            busy_cnt <= cal_busy_o[0] ? busy_cnt + 12'h001 : 12'h000;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_ok_pulse_one: assert property (
        frame_ok_o |=> !frame_ok_o && !frame_err_o)
        else $error("frame ok pulse too long");
    a_err_no_change: assert property (
        frame_err_o |=> $stable(dac_code_o) && $stable(clear_enable_o))
        else $error("bad frame changed state");
    a_code_has_cause: assert property (
        !$stable(dac_code_o) |-> frame_ok_o || clr_age != 4'hF)
        else $error("code changed without frame or clear");
    a_busy_from_write: assert property (
        |(cal_busy_o & ~$past(cal_busy_o)) |-> frame_ok_o)
        else $error("calibration started without frame");
    a_busy_length: assert property (
        $fell(cal_busy_o[0]) |-> busy_cnt >= 12'h7CB &&
        busy_cnt <= 12'h7D5)
        else $error("calibration length wrong");
    a_enable_cause: assert property (
        !$stable({output_drive_enable_o, clear_enable_o}) |-> frame_ok_o)
        else $error("enables changed without frame");
    a_read_latency: assert property (
        trim_valid_o |-> $past(trim_rd_i, 2))
        else $error("trim valid without request");
    a_code_cause: assert property (
        !$stable(packet_check_code_o) |-> frame_ok_o && packet_check_en_i)
        else $error("check code changed without checked frame");

    c_ok: cover property (frame_ok_o);
    c_err: cover property (frame_err_o);
    c_clear: cover property (clr_age == 4'h8);
    c_busy_done: cover property ($fell(cal_busy_o[0]));
endmodule

bind dacwd_top diwd_asserts #(.DW(DW), .NCH(NCH)) u_diwd_asserts (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
    .sdin_i(sdin_i), .sync_n_i(sync_n_i),
    .strap_pin_hi_i(strap_pin_hi_i), .strap_pin_lo_i(strap_pin_lo_i),
    .clear_i(clear_i), .packet_check_en_i(packet_check_en_i),
    .trim_rd_i(trim_rd_i), .trim_addr_i(trim_addr_i),
    .trim_data_o(trim_data_o), .trim_valid_o(trim_valid_o),
    .dac_code_o(dac_code_o), .cal_busy_o(cal_busy_o),
    .output_drive_enable_o(output_drive_enable_o),
    .clear_enable_o(clear_enable_o),
    .packet_check_code_o(packet_check_code_o),
    .frame_ok_o(frame_ok_o), .frame_err_o(frame_err_o));

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg         core_clk_i;
    reg         rst_i;
    reg         clear_i;
    reg         pce;
    reg         trim_rd;
    reg  [3:0]  trim_addr;
    reg         strap_hi;
    reg         strap_lo;
    wire        sclk;
    wire        sdin;
    wire        sync_n;
    wire [15:0] trim_data;
    wire        trim_valid;
    wire [63:0] code;
    wire [3:0]  output_drive_enable;
    wire [3:0]  clr_en;
    wire [3:0]  busy;
    wire [7:0]  pcc;
    wire        f_ok;
    wire        f_err;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         ok_n = 0;
    int         bad_n = 0;

    diwd_host_model u_diwd_host_model (
        .sclk_o(sclk), .sdin_o(sdin), .sync_n_o(sync_n));
    dacwd_top u_dacwd_top (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk),
        .sdin_i(sdin), .sync_n_i(sync_n), .strap_pin_hi_i(strap_hi),
        .strap_pin_lo_i(strap_lo), .clear_i(clear_i),
        .packet_check_en_i(pce), .trim_rd_i(trim_rd),
        .trim_addr_i(trim_addr), .trim_data_o(trim_data),
        .trim_valid_o(trim_valid), .dac_code_o(code),
        .output_drive_enable_o(output_drive_enable), .clear_enable_o(clr_en),
        .cal_busy_o(busy), .packet_check_code_o(pcc),
        .frame_ok_o(f_ok), .frame_err_o(f_err));

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (f_ok === 1'b1) ok_n++;
        if (f_err === 1'b1) bad_n++;
    end

    // ==========================================================
    // access tasks
    function automatic [23:0] w24(input [2:0] c, input [1:0] ch,
                                  input [15:0] d);
        w24 = {1'b0, 2'b10, c, ch, d};
    endfunction

    task automatic chk(input string nm, input logic [63:0] got,
                       input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic wr(input [23:0] w);
        u_diwd_host_model.send({w, 8'h00}, 24);
    endtask

    task automatic rd(input [3:0] a, input [15:0] e);
        int k;
        @(negedge core_clk_i);
        trim_addr = a;
        trim_rd = 1'b1;
        @(negedge core_clk_i);
        trim_rd = 1'b0;
        for (k = 0; k < 8 && trim_valid !== 1'b1; k++)
            @(negedge core_clk_i);
        chk("trim_valid", trim_valid, 1'b1);
        chk("trim_data", trim_data, e);
    endtask

    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #2000000;
        error_cnt++;
        $display("watchdog expired");
        give_verdict;
    end

    // ==========================================================
    // tests
    initial begin
        int i;
        int n0;
        int b0;
        rst_i = 1'b1;
        clear_i = 1'b0;
        pce = 1'b0;
        trim_rd = 1'b0;
        trim_addr = 4'h0;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        repeat (8) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        for (i = 0; i < 4; i++) begin
            rd({2'h0, i[1:0]}, 16'hFFFF);
            rd({2'h1, i[1:0]}, 16'h8000);
            rd({2'h2, i[1:0]}, 16'h0000);
        end
        chk("code", code, 64'h0);
        chk("reset_err", bad_n, 0);
        $display("test reset values done");

        // gain broadcast at half range, then channel 1 gain set to 1234
        wr(w24(3'h3, 2'h0, 16'h8000));
        wr(w24(3'h5, 2'h1, 16'h0001));
        wr(w24(3'h2, 2'h1, 16'h1234));
        wr(w24(3'h4, 2'h2, 16'h7FFF));
        wr(w24(3'h6, 2'h0, 16'h0BBB));
        wr(w24(3'h6, 2'h3, 16'h0DDD));
        for (i = 0; i < 4; i++) begin
            rd({2'h0, i[1:0]}, i == 1 ? 16'h1234 : 16'h8000);
            rd({2'h1, i[1:0]}, i == 2 ? 16'h7FFF : 16'h0001);
        end
        rd(4'h8, 16'h0BBB);
        rd(4'hB, 16'h0DDD);
        $display("test trim writes done");

        n0 = ok_n;
        b0 = bad_n;
        wr({1'b0, 2'b01, 3'h2, 2'h0, 16'hDEAD});
        wr({1'b0, 2'b10, 3'h1, 2'h0, 16'hDEAD});
        wr({1'b1, 2'b10, 3'h2, 2'h0, 16'hDEAD});
        u_diwd_host_model.send({w24(3'h2, 2'h0, 16'hDEAD), 8'h00}, 23);
        wr(w24(3'h7, 2'h0, 16'h2060));
        chk("ok_count", ok_n - n0, 4);
        chk("err_count", bad_n - b0, 1);
        rd(4'h0, 16'h8000);
        chk("output_drive_enable", output_drive_enable, 4'h0);
        strap_hi = 1'b0;
        strap_lo = 1'b1;
        repeat (4) @(negedge core_clk_i);
        wr({1'b0, 2'b01, 3'h2, 2'h0, 16'h4321});
        rd(4'h0, 16'h4321);
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        repeat (4) @(negedge core_clk_i);
        $display("test refusals done");

        wr(w24(3'h0, 2'h0, 16'h5A5A));
        chk("code_a", code[15:0], 16'h5A5A);
        chk("busy_a", busy[0], 1'b1);
        @(negedge core_clk_i);
        pce = 1'b1;
        u_diwd_host_model.send({w24(3'h0, 2'h3, 16'h1357), 8'hA5}, 32);
        chk("code_d", code[63:48], 16'h1357);
        chk("check_code", pcc, 8'hA5);
        @(negedge core_clk_i);
        pce = 1'b0;
        $display("test data words done");

        #200000;
        chk("busy_a", busy[0], 1'b0);
        wr(w24(3'h7, 2'h0, 16'h4060));
        chk("output_drive_enable", output_drive_enable, 4'h1);
        chk("clr_en", clr_en, 4'h1);
        @(negedge core_clk_i);
        clear_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        clear_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        chk("clear_a", code[15:0], 16'h0BBB);
        chk("clear_d", code[63:48], 16'h1357);
        $display("test control and clear done");
        give_verdict;
    end
endmodule
